// ===== inc/cfg_ident_pkg.sv
package cfg_ident_pkg;
	localparam logic [7:0] ident_offset = 8'h00;
	localparam logic [7:0] command_offset = 8'h04;
	localparam logic [15:0] command_reset = 16'h0000;
	localparam logic [15:0] command_write_mask = 16'h0357;
	localparam logic [15:0] maker_identifier_value = 16'hA5A5;
	localparam logic [15:0] product_legacy_value = 16'h0E01;
	localparam logic [15:0] product_enhanced_value = 16'h0E02;
	localparam int io_space_bit = 0;
	localparam int memory_space_bit = 1;
	localparam int bus_master_bit = 2;
	localparam int write_invalidate_bit = 4;
	localparam int parity_response_bit = 6;
	localparam int system_error_bit = 8;
	localparam int fast_b2b_bit = 9;
	localparam int parity_flag_bit = 31;
	localparam int lane_command_low = 0;
	localparam int lane_command_high = 1;
	localparam int lane_status_high = 3;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] byte_en;
		logic [31:0] wdata;
	} cfg_req_type;

	typedef struct packed {
		logic mem_hit;
		logic io_hit;
		logic master_request;
	} bus_event_type;

	typedef struct packed {
		logic mem_claim;
		logic io_claim;
		logic master_start;
	} bus_grant_type;
endpackage

// ===== logic/cfg_ident_regs.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Maker identifier is a fixed read-only code; writes change nothing.
// - Product identifier is read-only and differs between legacy and enhanced function.
// - Command all zero means only configuration accesses are answered.
// - Command is 16 bits, resets to zero; 15:10 reserved, 7,5,3 read-only.
// - Bit 9 enables fast back-to-back transfers to different agents.
// - Bit 8 gates the system error driver; clear means never driven.
// - Address parity error reported only when bits 8 and 6 both set.
// - With bit 6 clear, flag still set, no parity error pin, parity generated.
// - Bit 2 clear forbids starting transactions as bus master.
module cfg_ident_regs #(
	parameter bit is_enhanced = 1'b0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire cfg_ident_pkg::cfg_req_type cfg_req,
	output logic cfg_ack,
	output logic [31:0] cfg_rdata,
	input wire cfg_ident_pkg::bus_event_type bus_event,
	output cfg_ident_pkg::bus_grant_type bus_grant,
	input wire logic addr_parity_err,
	input wire logic data_parity_err,
	input wire logic [35:0] parity_source,
	output logic parity_out,
	output logic serr_n_out,
	output logic serr_oe,
	output logic perr_n_out,
	output logic perr_oe,
	output logic fast_b2b_enable,
	output logic write_invalidate_enable
);
	import cfg_ident_pkg::*;

	logic [15:0] command_control;
	logic detected_parity_error;
	logic [15:0] product_identifier;
	logic [15:0] next_command;
	logic next_parity_flag;
	logic [31:0] next_rdata;
	logic hit_ident;
	logic hit_command;
	logic cmd_write;
	logic parity_flag_clear;
	logic parity_seen;
	logic report_serr;
	logic report_perr;
	logic rd_ident;
	logic rd_command;
	logic [31:0] ident_word;
	logic [31:0] command_word;
	logic mem_enable;
	logic io_enable;
	logic master_enable;
	logic parity_calc;
	logic lane_low_write;
	logic lane_high_write;

	function automatic logic [7:0] lane_merge(input logic [7:0] old, input logic [7:0] data,
		input logic en, input logic [7:0] mask);
		lane_merge = en ? ((old & ~mask) | (data & mask)) : old;
	endfunction

	assign product_identifier = is_enhanced ? product_enhanced_value : product_legacy_value;
	assign hit_ident = cfg_req.addr == ident_offset;
	assign hit_command = cfg_req.addr == command_offset;
	assign cmd_write = cfg_req.valid && cfg_req.write && hit_command;
	assign lane_low_write = cmd_write && cfg_req.byte_en[lane_command_low];
	assign lane_high_write = cmd_write && cfg_req.byte_en[lane_command_high];
	// Only writable bits take data, so reserved and read-only bits stay zero even if
	// software breaks the convention of writing them as zero.
	assign next_command[7:0] = lane_merge(command_control[7:0], cfg_req.wdata[7:0],
		lane_low_write, command_write_mask[7:0]);
	assign next_command[15:8] = lane_merge(command_control[15:8], cfg_req.wdata[15:8],
		lane_high_write, command_write_mask[15:8]);
	assign parity_flag_clear = cmd_write && cfg_req.byte_en[lane_status_high]
		&& cfg_req.wdata[parity_flag_bit];
	assign parity_seen = addr_parity_err || data_parity_err;
	// Set beats clear so an error in the clearing cycle is not lost.
	assign next_parity_flag = parity_seen
		|| (detected_parity_error && !parity_flag_clear);
	assign report_serr = addr_parity_err && command_control[system_error_bit]
		&& command_control[parity_response_bit];
	assign report_perr = data_parity_err && command_control[parity_response_bit];
	assign rd_ident = !cfg_req.write && hit_ident;
	assign rd_command = !cfg_req.write && hit_command;
	assign ident_word = {product_identifier, maker_identifier_value};
	assign command_word = {detected_parity_error, 15'h0000, command_control};
	// Writes and unmapped offsets read as zero, so a stray probe never sees stale data.
	assign next_rdata = rd_ident ? ident_word
		: rd_command ? command_word
		: 32'h0000_0000;
	assign mem_enable = command_control[memory_space_bit];
	assign io_enable = command_control[io_space_bit];
	assign master_enable = command_control[bus_master_bit];
	assign parity_calc = ^parity_source;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			command_control <= command_reset;
			detected_parity_error <= 1'b0;
			cfg_ack <= 1'b0;
			cfg_rdata <= 32'h0000_0000;
		end else begin
			command_control <= next_command;
			detected_parity_error <= next_parity_flag;
			cfg_ack <= cfg_req.valid;
			cfg_rdata <= cfg_req.valid ? next_rdata : 32'h0000_0000;
		end
	end

	// Claims are gated by the enables, so a zero command leaves configuration alone.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			bus_grant <= '0;
			serr_oe <= 1'b0;
			perr_oe <= 1'b0;
			parity_out <= 1'b0;
		end else begin
			bus_grant.mem_claim <= bus_event.mem_hit
				&& mem_enable;
			bus_grant.io_claim <= bus_event.io_hit && io_enable;
			bus_grant.master_start <= bus_event.master_request
				&& master_enable;
			serr_oe <= report_serr;
			perr_oe <= report_perr;
			parity_out <= parity_calc;
		end
	end

	// Open-drain pins only ever pull low; the enable alone decides whether they act.
	always_ff @(posedge core_clk) begin
		if (reset) begin
			serr_n_out <= 1'b1;
			perr_n_out <= 1'b1;
			fast_b2b_enable <= 1'b0;
			write_invalidate_enable <= 1'b0;
		end else begin
			serr_n_out <= !report_serr;
			perr_n_out <= !report_perr;
			fast_b2b_enable <= command_control[fast_b2b_bit];
			write_invalidate_enable <= command_control[write_invalidate_bit];
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_ident_read_value: assert property (cfg_req.valid && !cfg_req.write && hit_ident
		|=> cfg_ack && cfg_rdata == {product_identifier, maker_identifier_value})
		else $error("identification read returned wrong value");
	a_product_per_function: assert property (cfg_req.valid && rd_ident
		|=> cfg_rdata == {(is_enhanced ? product_enhanced_value : product_legacy_value),
		maker_identifier_value})
		else $error("product identifier does not match function");
	a_ident_write_ignored: assert property (cfg_req.valid && hit_ident
		&& cfg_req.write |=> $stable(command_control))
		else $error("identification write changed the command register");
	a_zero_cmd_no_claim: assert property (command_control == 16'h0000
		|=> !bus_grant.mem_claim && !bus_grant.io_claim && !bus_grant.master_start)
		else $error("claim made while command is zero");
	a_config_always_acked: assert property (cfg_req.valid
		&& command_control == 16'h0000 |=> cfg_ack)
		else $error("configuration access not acknowledged");
	a_idle_no_ack: assert property (!cfg_req.valid
		|=> !cfg_ack && cfg_rdata == 32'h0000_0000)
		else $error("acknowledge or data without a request");
	a_fixed_bits_zero: assert property (
		(command_control & ~command_write_mask) == 16'h0000)
		else $error("reserved or read-only command bit set");
	a_write_lands: assert property (cmd_write && (&cfg_req.byte_en)
		|=> command_control == ($past(cfg_req.wdata[15:0]) & command_write_mask))
		else $error("command write did not land as masked");
	a_invalidate_follows: assert property (##1 write_invalidate_enable
		== $past(command_control[write_invalidate_bit]))
		else $error("write and invalidate output does not follow command");
	a_b2b_follows_bit: assert property (##1 fast_b2b_enable
		== $past(command_control[fast_b2b_bit]))
		else $error("fast back-to-back output does not follow command");
	a_serr_gated: assert property (serr_oe |-> $past(addr_parity_err)
		&& $past(command_control[system_error_bit]) && $past(command_control[parity_response_bit]))
		else $error("system error driven without cause or enable");
	a_serr_needs_enable: assert property (!command_control[system_error_bit]
		|=> !serr_oe && serr_n_out)
		else $error("system error driven while its driver is disabled");
	a_serr_pin_pair: assert property (serr_oe == !serr_n_out)
		else $error("system error enable and data disagree");
	a_serr_reported: assert property (report_serr |=> serr_oe && !serr_n_out)
		else $error("address parity error not reported");
	a_parity_flag_set: assert property (parity_seen |=> detected_parity_error)
		else $error("parity flag not set on error");
	a_parity_flag_clears: assert property (parity_flag_clear && !parity_seen
		|=> !detected_parity_error)
		else $error("parity flag not cleared by write");
	a_perr_needs_enable: assert property (!command_control[parity_response_bit] |=> !perr_oe)
		else $error("parity error pin driven while response disabled");
	a_perr_reported: assert property (report_perr
		|=> perr_oe && !perr_n_out)
		else $error("data parity error not reported");
	a_parity_generated: assert property (##1 parity_out
		== $past(parity_calc))
		else $error("generated parity does not match source");
	a_master_gated: assert property (bus_grant.master_start
		|-> $past(command_control[bus_master_bit]))
		else $error("master start while bus master disabled");
	a_master_started: assert property (bus_event.master_request && master_enable
		|=> bus_grant.master_start)
		else $error("enabled master request not started");
	a_mem_claim_gated: assert property (bus_event.mem_hit && mem_enable
		|=> bus_grant.mem_claim)
		else $error("enabled memory hit not claimed");
	a_mem_blocked: assert property (!mem_enable
		|=> !bus_grant.mem_claim)
		else $error("memory claim while memory space disabled");
	a_io_claim_gated: assert property (bus_event.io_hit && io_enable
		|=> bus_grant.io_claim)
		else $error("enabled I/O hit not claimed");
	a_io_blocked: assert property (!io_enable
		|=> !bus_grant.io_claim)
		else $error("I/O claim while I/O space disabled");

	c_command_write: cover property (cmd_write ##1 command_control != 16'h0000);
	c_serr_pulse: cover property (report_serr ##1 serr_oe);
	c_perr_pulse: cover property (report_perr ##1 perr_oe);
	c_parity_flag_cleared: cover property (detected_parity_error ##1 parity_flag_clear
		##1 !detected_parity_error);
	c_io_claim: cover property (bus_grant.io_claim);
endmodule

// ===== sim/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model
	import cfg_ident_pkg::*;
#(
	parameter bit all_fast = 1'b1
) (
	input wire logic core_clk,
	input wire logic cfg_ack,
	input wire logic [31:0] cfg_rdata,
	output cfg_ident_pkg::cfg_req_type cfg_req
);
	initial cfg_req = '0;
	// A missing acknowledge hands back unknowns so no compare can pass by luck.
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic [31:0] v;
		v = d;
		if (w && a == command_offset) begin
			v[15:10] = 6'h00;
			if (!all_fast) v[fast_b2b_bit] = 1'b0;
		end
		@(posedge core_clk);
		cfg_req <= {1'b1, w, a, 4'hF, v};
		@(posedge core_clk);
		cfg_req.valid <= 1'b0;
		#1 q = cfg_ack ? cfg_rdata : 'x;
	endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cfg_ident_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	cfg_req_type cfg_req;
	bus_event_type bus_event = '0;
	bus_grant_type bus_grant;
	logic addr_parity_err = 1'b0;
	logic data_parity_err = 1'b0;
	logic [35:0] parity_source = '0;
	logic cfg_ack, parity_out, serr_n_out, serr_oe, perr_n_out, perr_oe;
	logic fast_b2b_enable, write_invalidate_enable;
	logic [31:0] cfg_rdata, q;
	logic [31:0] enh_rdata;
	int failures = 0;
	int checks_done = 0;
	always #10 core_clk = ~core_clk;
	cfg_ident_regs i_dut (.core_clk, .reset, .cfg_req, .cfg_ack, .cfg_rdata, .bus_event,
		.bus_grant, .addr_parity_err, .data_parity_err, .parity_source, .parity_out,
		.serr_n_out, .serr_oe, .perr_n_out, .perr_oe, .fast_b2b_enable,
		.write_invalidate_enable);
	cfg_ident_regs #(.is_enhanced(1'b1)) i_dut_enh (.core_clk, .reset, .cfg_req, .cfg_ack(),
		.cfg_rdata(enh_rdata), .bus_event, .bus_grant(), .addr_parity_err, .data_parity_err,
		.parity_source, .parity_out(), .serr_n_out(), .serr_oe(), .perr_n_out(), .perr_oe(),
		.fast_b2b_enable(), .write_invalidate_enable());
	cfg_host_model i_host (.core_clk, .cfg_ack, .cfg_rdata, .cfg_req);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	task automatic end_sim;
		if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a);
		i_host.access(1'b0, a, 32'h0, q);
	endtask
	// Holds the events for exactly one sampled edge, then looks after the answer lands.
	task automatic pulse(input bus_event_type ev, input logic ap, input logic dp);
		@(posedge core_clk);
		bus_event <= ev;
		addr_parity_err <= ap;
		data_parity_err <= dp;
		parity_source <= 36'h1;
		@(posedge core_clk);
		bus_event <= '0;
		addr_parity_err <= 1'b0;
		data_parity_err <= 1'b0;
		parity_source <= 36'h3;
		#1;
	endtask
	initial begin
		repeat (2000) @(posedge core_clk);
		failures++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		rd(ident_offset);
		chk("ident", {product_legacy_value, maker_identifier_value}, q);
		chk("ident_enh", {product_enhanced_value, maker_identifier_value}, enh_rdata);
		wr(ident_offset, 32'hFFFF_FFFF);
		rd(ident_offset);
		chk("ident", {product_legacy_value, maker_identifier_value}, q);
		rd(command_offset);
		chk("command", 32'h0, q);
		wr(command_offset, 32'h0000_FFFF);
		rd(command_offset);
		chk("command", {16'h0, command_write_mask}, q);
		chk("enables", 32'h3, 32'({fast_b2b_enable, write_invalidate_enable}));
		pulse('1, 1'b0, 1'b0);
		chk("grant", 32'h7, 32'(bus_grant));
		chk("parity", 32'h1, 32'(parity_out));
		@(posedge core_clk);
		#1;
		chk("parity", 32'h0, 32'(parity_out));
		wr(command_offset, 32'h0);
		pulse('1, 1'b1, 1'b1);
		chk("grant", 32'h0, 32'(bus_grant));
		chk("pins", 32'h5, 32'({serr_oe, serr_n_out, perr_oe, perr_n_out}));
		chk("enables", 32'h0, 32'({fast_b2b_enable, write_invalidate_enable}));
		wr(command_offset, 32'h8000_0140);
		pulse('0, 1'b1, 1'b0);
		chk("pins", 32'h9, 32'({serr_oe, serr_n_out, perr_oe, perr_n_out}));
		pulse('0, 1'b0, 1'b1);
		chk("pins", 32'h6, 32'({serr_oe, serr_n_out, perr_oe, perr_n_out}));
		wr(command_offset, 32'h8000_0100);
		rd(command_offset);
		chk("command", 32'h0000_0100, q);
		pulse('0, 1'b1, 1'b1);
		chk("pins", 32'h5, 32'({serr_oe, serr_n_out, perr_oe, perr_n_out}));
		rd(command_offset);
		chk("command", 32'h8000_0100, q);
		wr(command_offset, 32'h0000_0357);
		@(posedge core_clk);
		reset <= 1'b1;
		repeat (2) @(posedge core_clk);
		reset <= 1'b0;
		rd(command_offset);
		chk("command", 32'h0, q);
		chk("enables", 32'h0, 32'({fast_b2b_enable, write_invalidate_enable}));
		end_sim();
	end
endmodule
